// ### hw/sfr_pkg.sv
// Purpose: shared constants and types of the special function register bank
// Assumes: 200 MHz clock, one instruction-cycle strobe supplied by the core
// Notes:   addresses serve both the register file and the I/O control space; control register has none
`default_nettype none
package sfr_pkg;
  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [5:0] ADDR_INDIRECT = 6'h00;
  localparam logic [5:0] ADDR_TIMER    = 6'h01;
  localparam logic [5:0] ADDR_STATUS   = 6'h03;
  localparam logic [5:0] ADDR_RSEL     = 6'h04;
  localparam logic [5:0] ADDR_PORT5    = 6'h05;
  localparam logic [5:0] ADDR_PORT6    = 6'h06;
  localparam logic [5:0] ADDR_PDOWN    = 6'h0b;
  localparam logic [5:0] ADDR_ODRAIN   = 6'h0c;
  localparam logic [5:0] ADDR_PHIGH    = 6'h0d;
  localparam logic [5:0] ADDR_WDCTL    = 6'h0e;
  localparam logic [5:0] ADDR_IRQ      = 6'h0f;
  localparam logic [5:0] ADDR_GPR_LO   = 6'h10;
  localparam logic [5:0] ADDR_GPR_HI   = 6'h2f;
  localparam logic [5:0] ADDR_LOW_TOP  = 6'h06;
  // ****************************************
  // bit positions and fixed masks
  // ****************************************
  localparam int ST_RST  = 7;
  localparam int ST_TO   = 4;
  localparam int ST_PD   = 3;
  localparam int CT_GIE  = 6;
  localparam int CT_TS   = 5;
  localparam int CT_TE   = 4;
  localparam int CT_PAB  = 3;
  localparam int WD_EN   = 7;
  localparam int WD_EIS  = 6;
  localparam logic [7:0] RSEL_FIXED   = 8'hc0;
  localparam logic [7:0] P5_MASK      = 8'h0f;
  localparam logic [7:0] PDOWN_FIXED  = 8'h88;
  localparam logic [7:0] ODRAIN_MASK  = 8'hf7;
  localparam logic [7:0] PHIGH_FIXED  = 8'h08;
  localparam logic [7:0] WDCTL_MASK   = 8'hc0;
  localparam logic [7:0] IRQ_MASK     = 8'h07;
  localparam logic [7:0] IMASK_FIXED  = 8'hf8;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_CTRL   = 8'hbf;
  localparam logic [7:0] RST_DIR5   = 8'h0f;
  localparam logic [7:0] RST_DIR6   = 8'hff;
  localparam logic [7:0] RST_PORT   = 8'hff;
  localparam logic [7:0] RST_PDOWN  = 8'hff;
  localparam logic [7:0] RST_ODRAIN = 8'h00;
  localparam logic [7:0] RST_PHIGH  = 8'hff;
  localparam logic [7:0] RST_WDCTL  = 8'h80;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_RSEL   = 8'hc0;
  // ****************************************
  // timing
  // ****************************************
  localparam int    CLK_PERIOD_PS = 5000;
  localparam real   WDT_PERIOD_MS = 23.5;
  localparam int    WDT_CYCLES    = int'(WDT_PERIOD_MS * 1.0e9 / CLK_PERIOD_PS);
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       io_space;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sfr_acc_s;
  typedef struct packed {
    logic clr_wdt;
    logic sleep;
    logic irq_on;
    logic irq_off;
    logic return_from_irq_instr;
    logic irq_taken;
    logic ctl_write;
  } sfr_instr_s;
endpackage : sfr_pkg
`default_nettype wire

// ### hw/sfr_prescaler.sv
// Purpose: shared 8-bit prescaler with ratio tap
// Assumes: tick is a one-cycle pulse
// Notes:   tap picks bit n (timer) or n-1 (watchdog, n=0 passes the tick)
`default_nettype none
module sfr_prescaler (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire logic       to_wdt,
  input  wire logic [2:0] ratio,
  // output
  output logic            out_pulse
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [8:0] chain;

  always_comb begin
    nxt_cnt = cnt_ff + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
    end else if (clr) begin
      cnt_ff <= 8'h00;
    end else if (tick) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // chain[k] = tick carries out of bit k-1: a pulse each 2^k ticks
  assign chain[0] = tick;
  generate
    for (genvar k = 0; k < 8; k++) begin : g_carry
      assign chain[k+1] = tick & (&cnt_ff[k:0]);
    end
  endgenerate

  // timer divides by 2^(n+1), watchdog by 2^n
  always_comb begin
    out_pulse = to_wdt ? chain[ratio] : chain[ratio + 4'd1];
  end
endmodule : sfr_prescaler
`default_nettype wire

// ### hw/sfr_port_pad.sv
// Purpose: per-pin pad control for one port
// Assumes: direction 1 means high impedance
// Notes:   open-drain pins drive only low
`default_nettype none
module sfr_port_pad (
  // register values
  input  wire logic [7:0] data,
  input  wire logic [7:0] dir,
  input  wire logic [7:0] odrain,
  input  wire logic [7:0] in_only,
  // pad
  output logic      [7:0] pad_out,
  output logic      [7:0] pad_oe
);
  generate
    for (genvar i = 0; i < 8; i++) begin : g_pin
      assign pad_out[i] = data[i];
      // high impedance when dir or in_only is one, or drive high released by open drain
      assign pad_oe[i]  = ~dir[i] & ~in_only[i] & ~(odrain[i] & data[i]);
    end
  endgenerate
endmodule : sfr_port_pad
`default_nettype wire

// ### hw/sfr_bank.sv
// Purpose: special function register bank of a small 8-bit controller
// Assumes: core gives one access and instruction strobes per instruction cycle
// Notes:   reads are combinational-free: rdata is registered one cycle after rd
//
// Contract
// - time-out flag set at power-up, watchdog clear, sleep; cleared at time-out
// - power-down flag set at power-on, watchdog clear; cleared by sleep
// - reset-type bit one after pin-change wake, else zero; bits 6,5 plain storage
// - pointer low six bits address indirect access; top two bits read one
// - port 5 data has four bits, upper read zero; port 6 bit 3 input only
// - flags set by interrupt pin fall, port 6 change, timer overflow
// - software may clear flags but never set them
// - flag read returns flags AND mask
// - global enable cleared by disable or taken interrupt, set by enable/return
// - source select: zero instruction cycle, one external timer pin
// - edge select: zero rising edge, one falling edge
// - assign bit gives prescaler to timer when zero, watchdog when one
// - ratio n divides timer by 2^(n+1), watchdog by 2^n
// - direction zero drives pin, one high impedance; port 5 four bits
// - pull-down control zero enables; bits 7 and 3 read one
// - open-drain control one makes pin open drain; bit 3 reads zero
// - pull-high control zero enables; bit 3 reads one
// - pin-function bit picks plain I/O or interrupt input on port 6 bit 0
// - mask bits enable flags; upper mask bits read one; global enable needed
// - prescaler clears on timer write or on watchdog clear/sleep; code: timer write only if assigned to timer, clear/sleep only if to watchdog
// - internal source counts once per instruction cycle
// - watchdog runs in sleep and resets device on time-out when enabled
`default_nettype none
module sfr_bank #(
  parameter int WDT_BASE_CYCLES = sfr_pkg::WDT_CYCLES
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // core side
  input  wire sfr_pkg::sfr_acc_s   acc,
  input  wire sfr_pkg::sfr_instr_s instr,
  input  wire logic                cycle_tick,
  input  wire logic                wake_pin_change,
  output logic [7:0]               rdata,
  output logic [7:0]               ctrl_rdata,
  output logic [5:0]               indirect_addr,
  output logic                     irq_req,
  output logic                     wdt_reset,
  // pins
  input  wire logic [7:0]          port5_in,
  input  wire logic [7:0]          port6_in,
  output logic [7:0]               port5_out,
  output logic [7:0]               port5_oe,
  output logic [7:0]               port6_out,
  output logic [7:0]               port6_oe,
  output logic [7:0]               pulldown_en,
  output logic [7:0]               pullup_en
);
  // ****************************************
  // storage
  // ****************************************
  logic [7:0] status_ff, rsel_ff, p5_ff, p6_ff, ctrl_ff, dir5_ff, dir6_ff;
  logic [7:0] pdown_ff, odrain_ff, phigh_ff, wdctl_ff, flag_ff, imask_ff;
  logic [7:0] timer_ff, rdata_ff, ctrl_rd_ff, p5o_ff, p5e_ff, p6o_ff, p6e_ff;
  logic [7:0] pd_ff, pu_ff, p6_prev_ff;
  logic       irq_ff, wdt_rst_ff, tpin_prev_ff, int_prev_ff, armed_ff;
  logic [31:0] wdt_cnt_ff;

  logic wr_reg, wr_io;
  assign wr_reg = acc.wr & ~acc.io_space;
  assign wr_io  = acc.wr &  acc.io_space;

  logic [5:0] eff_addr;
  assign eff_addr = (acc.addr == sfr_pkg::ADDR_INDIRECT) ? rsel_ff[5:0] : acc.addr;

  // ****************************************
  // timer and prescaler
  // ****************************************
  logic tpin, tpin_edge, tmr_src, tmr_pulse, wdt_src, wdt_pulse, pre_pulse, pre_clr, tmr_wr, ovf;
  logic to_wdt;
  assign to_wdt    = ctrl_ff[sfr_pkg::CT_PAB];
  assign tpin      = port6_in[2];
  assign tpin_edge = ctrl_ff[sfr_pkg::CT_TE] ? (tpin_prev_ff & ~tpin) : (~tpin_prev_ff & tpin);
  assign tmr_src   = ctrl_ff[sfr_pkg::CT_TS] ? tpin_edge : cycle_tick;
  assign wdt_src   = (wdt_cnt_ff >= 32'(WDT_BASE_CYCLES - 1));
  assign tmr_wr    = wr_reg & (eff_addr == sfr_pkg::ADDR_TIMER);
  assign pre_clr   = to_wdt ? (instr.clr_wdt | instr.sleep) : tmr_wr;

  sfr_prescaler u_pre (
    .clk       (clk),
    .rst_n     (rst_n),
    .clr       (pre_clr),
    .tick      (to_wdt ? wdt_src : tmr_src),
    .to_wdt    (to_wdt),
    .ratio     (ctrl_ff[2:0]),
    .out_pulse (pre_pulse)
  );
  assign tmr_pulse = to_wdt ? tmr_src : pre_pulse;
  assign wdt_pulse = to_wdt ? pre_pulse : wdt_src;
  assign ovf       = tmr_pulse & (timer_ff == 8'hff) & ~tmr_wr;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_ff     <= 8'h00;
      tpin_prev_ff <= 1'b0;
    end else begin
      tpin_prev_ff <= tpin;
      if (tmr_wr) begin
        timer_ff <= acc.wdata;
      end else if (tmr_pulse) begin
        timer_ff <= timer_ff + 8'h01;
      end
    end
  end

  // watchdog runs regardless of sleep; base count runs even when disabled, restarted by watchdog clear and sleep
  logic wdt_timeout;
  assign wdt_timeout = wdt_pulse & wdctl_ff[sfr_pkg::WD_EN];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_ff <= 32'h0;
      wdt_rst_ff <= 1'b0;
    end else begin
      wdt_rst_ff <= wdt_timeout;
      if (instr.clr_wdt | instr.sleep | wdt_src) begin
        wdt_cnt_ff <= 32'h0;
      end else begin
        wdt_cnt_ff <= wdt_cnt_ff + 32'h1;
      end
    end
  end

  // ****************************************
  // status and pointer
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_ff <= sfr_pkg::RST_STATUS;
      rsel_ff   <= sfr_pkg::RST_RSEL;
    end else begin
      if (wr_reg & (eff_addr == sfr_pkg::ADDR_STATUS)) begin
        status_ff[6:5] <= acc.wdata[6:5];
        status_ff[2:0] <= acc.wdata[2:0];
      end
      if (wake_pin_change) begin
        status_ff[sfr_pkg::ST_RST] <= 1'b1;
      end else if (wdt_timeout) begin
        status_ff[sfr_pkg::ST_RST] <= 1'b0;
      end
      if (wdt_timeout) begin
        status_ff[sfr_pkg::ST_TO] <= 1'b0;
      end else if (instr.clr_wdt | instr.sleep) begin
        status_ff[sfr_pkg::ST_TO] <= 1'b1;
      end
      if (instr.sleep) begin
        status_ff[sfr_pkg::ST_PD] <= 1'b0;
      end else if (instr.clr_wdt) begin
        status_ff[sfr_pkg::ST_PD] <= 1'b1;
      end
      if (wr_reg & (eff_addr == sfr_pkg::ADDR_RSEL)) begin
        rsel_ff <= acc.wdata | sfr_pkg::RSEL_FIXED;
      end
    end
  end

  // ****************************************
  // ports and I/O control
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p5_ff <= sfr_pkg::RST_PORT & sfr_pkg::P5_MASK;
      p6_ff <= sfr_pkg::RST_PORT;
    end else begin
      if (wr_reg & (eff_addr == sfr_pkg::ADDR_PORT5)) begin
        p5_ff <= acc.wdata & sfr_pkg::P5_MASK;
      end
      if (wr_reg & (eff_addr == sfr_pkg::ADDR_PORT6)) begin
        p6_ff <= acc.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir5_ff   <= sfr_pkg::RST_DIR5;
      dir6_ff   <= sfr_pkg::RST_DIR6;
      pdown_ff  <= sfr_pkg::RST_PDOWN;
      odrain_ff <= sfr_pkg::RST_ODRAIN;
      phigh_ff  <= sfr_pkg::RST_PHIGH;
      wdctl_ff  <= sfr_pkg::RST_WDCTL;
      imask_ff  <= sfr_pkg::IMASK_FIXED;
    end else if (wr_io) begin
      case (acc.addr)
        sfr_pkg::ADDR_PORT5:  dir5_ff   <= acc.wdata & sfr_pkg::P5_MASK;
        sfr_pkg::ADDR_PORT6:  dir6_ff   <= acc.wdata;
        sfr_pkg::ADDR_PDOWN:  pdown_ff  <= acc.wdata | sfr_pkg::PDOWN_FIXED;
        sfr_pkg::ADDR_ODRAIN: odrain_ff <= acc.wdata & sfr_pkg::ODRAIN_MASK;
        sfr_pkg::ADDR_PHIGH:  phigh_ff  <= acc.wdata | sfr_pkg::PHIGH_FIXED;
        sfr_pkg::ADDR_WDCTL:  wdctl_ff  <= acc.wdata & sfr_pkg::WDCTL_MASK;
        sfr_pkg::ADDR_IRQ:    imask_ff  <= acc.wdata | sfr_pkg::IMASK_FIXED;
        default: ;
      endcase
    end
  end

  // ****************************************
  // control register and interrupts
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= sfr_pkg::RST_CTRL;
    end else begin
      if (instr.ctl_write) begin
        ctrl_ff[7]   <= acc.wdata[7];
        ctrl_ff[5:0] <= acc.wdata[5:0];
      end
      if (instr.irq_off | instr.irq_taken) begin
        ctrl_ff[sfr_pkg::CT_GIE] <= 1'b0;
      end else if (instr.irq_on | instr.return_from_irq_instr) begin
        ctrl_ff[sfr_pkg::CT_GIE] <= 1'b1;
      end
    end
  end

  // external interrupt only seen when the pin is in interrupt function
  logic irq_pin_function_sel, int_fall, p6_change;
  logic [7:0] flag_set;
  assign irq_pin_function_sel       = wdctl_ff[sfr_pkg::WD_EIS];
  assign int_fall  = irq_pin_function_sel & int_prev_ff & ~port6_in[0];
  assign p6_change = armed_ff & |(p6_prev_ff ^ port6_in);
  assign flag_set  = {5'h00, int_fall, p6_change, ovf};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff     <= 8'h00;
      int_prev_ff <= 1'b1;
      p6_prev_ff  <= 8'h00;
      armed_ff    <= 1'b0;
    end else begin
      armed_ff    <= 1'b1;
      int_prev_ff <= port6_in[0];
      p6_prev_ff  <= port6_in;
      // writes can only clear; a same-cycle event still sets
      if (wr_reg & (eff_addr == sfr_pkg::ADDR_IRQ)) begin
        flag_ff <= ((flag_ff & acc.wdata) | flag_set) & sfr_pkg::IRQ_MASK;
      end else begin
        flag_ff <= (flag_ff | flag_set) & sfr_pkg::IRQ_MASK;
      end
    end
  end

  // ****************************************
  // read path and pin outputs (all registered)
  // ****************************************
  logic [7:0] rd_mux;
  logic [7:0] p6_view;
  assign p6_view = {port6_in[7:1], irq_pin_function_sel ? port6_in[0] : (dir6_ff[0] ? port6_in[0] : p6_ff[0])};

  always_comb begin
    rd_mux = 8'h00;
    if (acc.io_space) begin
      case (acc.addr)
        sfr_pkg::ADDR_PORT5:  rd_mux = dir5_ff;
        sfr_pkg::ADDR_PORT6:  rd_mux = dir6_ff;
        sfr_pkg::ADDR_PDOWN:  rd_mux = pdown_ff;
        sfr_pkg::ADDR_ODRAIN: rd_mux = odrain_ff;
        sfr_pkg::ADDR_PHIGH:  rd_mux = phigh_ff;
        sfr_pkg::ADDR_WDCTL:  rd_mux = wdctl_ff;
        sfr_pkg::ADDR_IRQ:    rd_mux = imask_ff;
        default:              rd_mux = 8'h00;
      endcase
    end else begin
      case (eff_addr)
        sfr_pkg::ADDR_TIMER:  rd_mux = timer_ff;
        sfr_pkg::ADDR_STATUS: rd_mux = status_ff;
        sfr_pkg::ADDR_RSEL:   rd_mux = rsel_ff | sfr_pkg::RSEL_FIXED;
        sfr_pkg::ADDR_PORT5:  rd_mux = port5_in & sfr_pkg::P5_MASK;
        sfr_pkg::ADDR_PORT6:  rd_mux = p6_view;
        sfr_pkg::ADDR_IRQ:    rd_mux = flag_ff & imask_ff;
        default:              rd_mux = 8'h00;
      endcase
    end
  end

  logic [7:0] p5_oe_c, p6_oe_c;
  sfr_port_pad u_pad5 (
    .data    (p5_ff),
    .dir     (dir5_ff | ~sfr_pkg::P5_MASK),
    .odrain  (8'h00),
    .in_only (8'h00),
    .pad_out (),
    .pad_oe  (p5_oe_c)
  );
  sfr_port_pad u_pad6 (
    .data    (p6_ff),
    .dir     (dir6_ff | {5'h00, ctrl_ff[sfr_pkg::CT_TS], 2'b00}),
    .odrain  (odrain_ff),
    .in_only (8'h08),
    .pad_out (),
    .pad_oe  (p6_oe_c)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff   <= 8'h00;
      ctrl_rd_ff <= sfr_pkg::RST_CTRL;
      p5o_ff     <= 8'h00;
      p5e_ff     <= 8'h00;
      p6o_ff     <= 8'h00;
      p6e_ff     <= 8'h00;
      pd_ff      <= 8'h00;
      pu_ff      <= 8'h00;
      irq_ff     <= 1'b0;
    end else begin
      rdata_ff   <= rd_mux;
      ctrl_rd_ff <= ctrl_ff;
      p5o_ff     <= p5_ff;
      p5e_ff     <= p5_oe_c;
      p6o_ff     <= p6_ff;
      p6e_ff     <= p6_oe_c;
      // pull-down map: port6 bits 0-2 from bits 6-4, port5 bits 0-2 from bits 2-0
      pd_ff      <= {1'b0, ~pdown_ff[6:4], 1'b0, ~pdown_ff[2:0]};
      pu_ff      <= ~phigh_ff & ~sfr_pkg::PHIGH_FIXED;
      irq_ff     <= ctrl_ff[sfr_pkg::CT_GIE] & |(flag_ff & imask_ff & sfr_pkg::IRQ_MASK);
    end
  end

  assign rdata         = rdata_ff;
  assign ctrl_rdata    = ctrl_rd_ff;
  assign indirect_addr = rsel_ff[5:0];
  assign irq_req       = irq_ff;
  assign wdt_reset     = wdt_rst_ff;
  assign port5_out     = p5o_ff;
  assign port5_oe      = p5e_ff;
  assign port6_out     = p6o_ff;
  assign port6_oe      = p6e_ff;
  assign pulldown_en   = pd_ff;
  assign pullup_en     = pu_ff;

  // ****************************************
  // checks
  // ****************************************
  a_flag_no_set: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_reg && eff_addr == sfr_pkg::ADDR_IRQ && flag_set == 8'h00) |=> ((flag_ff & ~$past(flag_ff)) == 8'h00))
    else $error("flag set by software write");
  a_gie_off: assert property (@(posedge clk) disable iff (!rst_n)
    (instr.irq_off) |=> !ctrl_ff[sfr_pkg::CT_GIE])
    else $error("global enable not cleared");
  a_pd_sleep: assert property (@(posedge clk) disable iff (!rst_n)
    instr.sleep |=> !status_ff[sfr_pkg::ST_PD])
    else $error("power-down flag not cleared by sleep");
  a_to_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_timeout |=> !status_ff[sfr_pkg::ST_TO] && wdt_reset)
    else $error("time-out flag or reset missing");
  a_ovf_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ovf |=> timer_ff == 8'h00 && flag_ff[0])
    else $error("overflow did not wrap and flag");
  a_rsel_top: assert property (@(posedge clk) disable iff (!rst_n)
    rsel_ff[7:6] == 2'b11)
    else $error("pointer top bits not one");
  a_p5_upper: assert property (@(posedge clk) disable iff (!rst_n)
    p5_ff[7:4] == 4'h0 && !port6_oe[3])
    else $error("port 5 upper bits or port 6 bit 3 driven");
  a_irq_out: assert property (@(posedge clk) disable iff (!rst_n)
    irq_req |-> $past(ctrl_ff[sfr_pkg::CT_GIE]))
    else $error("interrupt without global enable");
endmodule : sfr_bank
`default_nettype wire

// ### testbench/sfr_core_model.sv
// Purpose: core model issuing register accesses and instruction strobes
// Assumes: requests change on the falling edge and are held over one rising edge
// Notes:   read data is taken one cycle after the address is presented
`default_nettype none
module sfr_core_model (
  // clock and read data
  input  wire logic               clk,
  input  wire logic [7:0]         rdata,
  // bank side
  output var sfr_pkg::sfr_acc_s   acc,
  output var sfr_pkg::sfr_instr_s instr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    acc = '0;
    instr = '0;
  end
  task automatic wr(input logic io, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    acc <= '{wr: 1'b1, rd: 1'b0, io_space: io, addr: a, wdata: d};
    @(negedge clk);
    acc <= '0;
  endtask : wr
  task automatic rd(input logic io, input logic [5:0] a, output logic [7:0] q);
    @(negedge clk);
    acc <= '{wr: 1'b0, rd: 1'b1, io_space: io, addr: a, wdata: 8'h00};
    @(negedge clk);
    q = rdata;
    acc <= '0;
  endtask : rd
  // instruction strobe; control writes carry their value on wdata
  task automatic op(input sfr_pkg::sfr_instr_s i, input logic [7:0] d);
    @(negedge clk);
    instr <= i;
    acc.wdata <= d;
    @(negedge clk);
    instr <= '0;
    acc <= '0;
  endtask : op
endmodule : sfr_core_model
`default_nettype wire

// ### testbench/sfr_bank_tb_top.sv
// Purpose: self-checking bench of the register bank
// Assumes: watchdog base count shortened to 16 cycles
// Notes:   port 5 pins held high; inputs change on the falling edge
`default_nettype none
module sfr_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                tick = 1'b0;
  logic                wake = 1'b0;
  logic [7:0]          p6_in = 8'hff;
  logic [7:0]          p5_in = 8'hff;
  logic [7:0]          rdata, ctrl_rdata, p5_oe, p6_oe, pd_en, pu_en, q, p5_out, p6_out;
  logic [5:0]          ind;
  logic                irq, wdt_rst;
  sfr_pkg::sfr_acc_s   acc;
  sfr_pkg::sfr_instr_s instr;
  int                  err_total = 0;
  int                  comparisons = 0;
  int                  cyc = 0;
  localparam sfr_pkg::sfr_instr_s I_CLR = '{clr_wdt: 1'b1, default: 1'b0};
  localparam sfr_pkg::sfr_instr_s I_SLP = '{sleep: 1'b1, default: 1'b0};
  localparam sfr_pkg::sfr_instr_s I_ON = '{irq_on: 1'b1, default: 1'b0};
  localparam sfr_pkg::sfr_instr_s I_OFF = '{irq_off: 1'b1, default: 1'b0};
  localparam sfr_pkg::sfr_instr_s I_RET = '{return_from_irq_instr: 1'b1, default: 1'b0};
  localparam sfr_pkg::sfr_instr_s I_TKN = '{irq_taken: 1'b1, default: 1'b0};
  localparam sfr_pkg::sfr_instr_s I_CTL = '{ctl_write: 1'b1, default: 1'b0};
  always #2.5 clk = ~clk;
  sfr_bank #(.WDT_BASE_CYCLES(16)) DUT (.clk(clk), .rst_n(rst_n), .acc(acc), .instr(instr),
    .cycle_tick(tick), .wake_pin_change(wake), .rdata(rdata), .ctrl_rdata(ctrl_rdata),
    .indirect_addr(ind), .irq_req(irq), .wdt_reset(wdt_rst), .port5_in(p5_in), .port6_in(p6_in),
    .port5_out(p5_out), .port5_oe(p5_oe), .port6_out(p6_out), .port6_oe(p6_oe), .pulldown_en(pd_en),
    .pullup_en(pu_en));
  sfr_core_model core (.clk(clk), .rdata(rdata), .acc(acc), .instr(instr));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rchk(input string n, input logic io, input logic [5:0] a, input logic [7:0] e);
    core.rd(io, a, q);
    chk(n, q, e);
  endtask : rchk
  task automatic wc(input string n, input logic io, input logic [5:0] a, input logic [7:0] d,
                    input logic [7:0] e);
    core.wr(io, a, d);
    rchk(n, io, a, e);
  endtask : wc
  task automatic opc(input sfr_pkg::sfr_instr_s i, input logic [7:0] e);
    core.op(i, 8'h00);
    @(negedge clk);
    chk("gie", ctrl_rdata & 8'h40, e);
  endtask : opc
  task automatic stat(input logic [7:0] e);
    core.rd(1'b0, 6'h03, q);
    chk("status", q & 8'h98, e);
  endtask : stat
  // timer pin pattern, each level held three cycles
  task automatic pin2(input logic v);
    @(negedge clk);
    p6_in[2] = v;
    repeat (2) @(negedge clk);
  endtask : pin2
  task automatic close_out;
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rchk("status", 1'b0, 6'h03, 8'h18);
    rchk("rsel", 1'b0, 6'h04, 8'hc0);
    rchk("pdown", 1'b1, 6'h0b, 8'hff);
    rchk("odrain", 1'b1, 6'h0c, 8'h00);
    rchk("phigh", 1'b1, 6'h0d, 8'hff);
    rchk("imask", 1'b1, 6'h0f, 8'hf8);
    chk("ctrl", ctrl_rdata, 8'hbf);
  endtask : t_reset
  task automatic t_pins;
    core.wr(1'b1, 6'h0e, 8'h00);
    core.op(I_CTL, 8'h08);
    wc("pdown", 1'b1, 6'h0b, 8'h00, 8'h88);
    wc("odrain", 1'b1, 6'h0c, 8'hff, 8'hf7);
    wc("phigh", 1'b1, 6'h0d, 8'h00, 8'h08);
    wc("rsel", 1'b0, 6'h04, 8'h2a, 8'hea);
    chk("ind", {2'b00, ind}, 8'h2a);
    wc("imask", 1'b1, 6'h0f, 8'h00, 8'hf8);
    chk("pd_en", pd_en, 8'h77);
    chk("pu_en", pu_en, 8'hf7);
    core.wr(1'b1, 6'h06, 8'h00);
    core.wr(1'b0, 6'h04, 8'h06);
    core.wr(1'b0, 6'h00, 8'h5a);
    core.wr(1'b1, 6'h05, 8'h00);
    @(negedge clk);
    chk("p6_oe", p6_oe, 8'ha5);
    chk("p5_oe", p5_oe, 8'h0f);
    chk("p6_out", p6_out, 8'h5a);
    chk("p5_out", p5_out, 8'h0f);
    rchk("p5_in", 1'b0, 6'h05, 8'h0f);
    core.wr(1'b1, 6'h0c, 8'h00);
    @(negedge clk);
    chk("p6_oe", p6_oe, 8'hf7);
    core.wr(1'b1, 6'h06, 8'hff);
    @(negedge clk);
    chk("p6_oe", p6_oe, 8'h00);
  endtask : t_pins
  task automatic t_flags;
    core.wr(1'b1, 6'h0e, 8'h40);
    core.wr(1'b1, 6'h0f, 8'h07);
    wc("flagset", 1'b0, 6'h0f, 8'hff, 8'h00);
    @(negedge clk);
    p6_in[0] = 1'b0;
    repeat (3) @(negedge clk);
    rchk("flags", 1'b0, 6'h0f, 8'h06);
    wc("flagand", 1'b1, 6'h0f, 8'h04, 8'hfc);
    rchk("flags", 1'b0, 6'h0f, 8'h04);
    opc(I_ON, 8'h40);
    chk("irq", {7'h00, irq}, 8'h01);
    opc(I_TKN, 8'h00);
    opc(I_RET, 8'h40);
    opc(I_OFF, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    p6_in[0] = 1'b1;
    repeat (3) @(negedge clk);
    core.wr(1'b0, 6'h0f, 8'h00);
    core.wr(1'b1, 6'h0f, 8'h07);
    rchk("flagclr", 1'b0, 6'h0f, 8'h00);
  endtask : t_flags
  task automatic t_timer;
    for (int n = 0; n < 8; n++) begin
      core.op(I_CTL, {5'b00000, 3'(n)});
      core.wr(1'b0, 6'h01, 8'h00);
      repeat (3 << (n + 1)) begin
        @(negedge clk);
        tick = 1'b1;
        @(negedge clk);
        tick = 1'b0;
      end
      rchk("tmr", 1'b0, 6'h01, 8'h03);
    end
    core.op(I_CTL, 8'h00);
    core.wr(1'b0, 6'h01, 8'hfe);
    repeat (4) begin
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
    end
    rchk("wrap", 1'b0, 6'h01, 8'h00);
    rchk("tflag", 1'b0, 6'h0f, 8'h01);
    for (int te = 0; te < 2; te++) begin
      core.op(I_CTL, te ? 8'h38 : 8'h28);
      core.wr(1'b0, 6'h01, 8'h00);
      pin2(1'b0);
      pin2(1'b1);
      pin2(1'b0);
      rchk("ext", 1'b0, 6'h01, te ? 8'h02 : 8'h01);
      pin2(1'b1);
    end
  endtask : t_timer
  task automatic t_wdt;
    int k;
    k = 0;
    core.op(I_CTL, 8'h08);
    core.wr(1'b1, 6'h0e, 8'h80);
    core.op(I_CLR, 8'h00);
    while (wdt_rst !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("wdt", {7'h00, wdt_rst}, 8'h01);
    stat(8'h08);
    core.op(I_CLR, 8'h00);
    stat(8'h18);
    core.op(I_SLP, 8'h00);
    stat(8'h10);
    @(negedge clk);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    stat(8'h90);
  endtask : t_wdt
  // ****************************************
  // main sequence and hang guard
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_pins();
    t_flags();
    t_timer();
    t_wdt();
    close_out();
  end
endmodule : sfr_bank_tb_top
`default_nettype wire
